// ### hw/sad_defines.vh
// address decode constants for the system address decoder with external memory port
// assumes a 32-bit byte address space and a 50 MHz bus clock
// Summary of operation
// - external memory access takes four bus clocks per beat; 8-bit mode takes one beat per byte
// - one memory type, sync or async, selected
// - at most 24 external address bits
// - external data path 8 or 16 bits
// - address and control go to logic blocks
// - fetches from external memory served, slower, unprotected
// - region at zero is program code
// - six top-level regions decoded by top bits
// - bit-band alias maps one bit atomically
// - alias reads return zero or one
// - unaligned SRAM word and halfword crossing a word split into two beats
// - code buses carry only code range
// - system bus carries SRAM through external, above private
// - fetches allowed on system bus in SRAM region
// - system control reached only over private bus
// - port control window and external data window
// - two 32 KB SRAM halves around boundary
// - clocking, power, USB peripheral windows
`ifndef SAD_DEFINES_VH
`define SAD_DEFINES_VH
`define SAD_CODE_END 32'h1FFF_FFFF
`define SAD_SRAM_BASE 32'h2000_0000
`define SAD_SRAM_END 32'h3FFF_FFFF
`define SAD_PERI_BASE 32'h4000_0000
`define SAD_XRAM_BASE 32'h6000_0000
`define SAD_XPERI_BASE 32'hA000_0000
`define SAD_PRIV_BASE 32'hE000_0000
`define SAD_PRIV_END 32'hE00F_FFFF
`define SAD_SYSHI_BASE 32'hE010_0000
`define SAD_FLASH_END 32'h0003_FFFF
`define SAD_SRAM_LO_BASE 32'h1FFF_8000
`define SAD_SRAM_HI_END 32'h2000_7FFF
`define SAD_BB_END 32'h200F_FFFF
`define SAD_ALIAS_BASE 32'h2200_0000
`define SAD_ALIAS_END 32'h23FF_FFFF
`define SAD_CLK_BASE 32'h4000_4000
`define SAD_CLK_END 32'h4000_42FF
`define SAD_PWR_BASE 32'h4000_4300
`define SAD_PWR_END 32'h4000_43FF
`define SAD_XCTL_BASE 32'h4000_5400
`define SAD_XCTL_END 32'h4000_54FF
`define SAD_USB_BASE 32'h4000_6000
`define SAD_USB_END 32'h4000_60FF
`define SAD_NVB_BASE 32'h4000_8000
`define SAD_NVB_END 32'h4000_87FF
`define SAD_ECC_BASE 32'h4800_0000
`define SAD_ECC_END 32'h4800_7FFF
`define SAD_XDATA_END 32'h60FF_FFFF
`define SAD_RSV_BASE 32'h4000_A000
`define SAD_RSV_END 32'h4000_A400
`define SAD_SRAM_AW 14
`define SAD_XADDR_W 24
`define SAD_XCYCLES 3'h4
`define SAD_CLK_MHZ 50
`define SAD_REF_MHZ 33
// target select codes
`define SAD_T_NONE 4'h0
`define SAD_T_SRAM 4'h1
`define SAD_T_FLASH 4'h2
`define SAD_T_CLK 4'h3
`define SAD_T_PWR 4'h4
`define SAD_T_XCTL 4'h5
`define SAD_T_USB 4'h6
`define SAD_T_NVB 4'h7
`define SAD_T_ECC 4'h8
`define SAD_T_XMEM 4'h9
`define SAD_T_PRIV 4'hA
`define SAD_T_SYS 4'hB
`endif

// ### hw/sad_sram.v
// on-chip SRAM, 64 KB as 16K words with byte writes
// read data registered one cycle after the address
`timescale 1ns/10ps
`include "sad_defines.vh"
module sad_sram (
	clk,
	addr,
	wrEn,
	byteEn,
	wrData,
	rdData
);
	input wire clk;
	input wire [`SAD_SRAM_AW-1:0] addr;
	input wire wrEn;
	input wire [3:0] byteEn;
	input wire [31:0] wrData;
	output reg [31:0] rdData;
	wire [31:0] rdLane;
	genvar b;
	generate
		for (b = 0; b < 4; b = b + 1) begin : lane
			// one array per byte lane keeps each array on a single writer
			reg [7:0] mem [0:(1<<`SAD_SRAM_AW)-1];
			always @(posedge clk) begin
				if (wrEn && byteEn[b]) begin
					mem[addr] <= wrData[8*b+7:8*b];
				end
			end
			assign rdLane[8*b+7:8*b] = mem[addr];
		end
	endgenerate
	always @(posedge clk) begin
		rdData <= rdLane;
	end
endmodule

// ### hw/sad_decoder.v
// system address decoder: region steering, SRAM with bit-band, external memory port
// assumes a single requesting master holding req until done; external device answers in fixed time
`timescale 1ns/10ps
`include "sad_defines.vh"
module sad_decoder (
	clk,
	rst,
	req,
	fetch,
	write,
	size,
	addr,
	wrData,
	viaPrivBus,
	xmemSync,
	xmemWide,
	done,
	busError,
	rdData,
	codeBusSel,
	sysBusSel,
	privBusSel,
	periphSel,
	periphAddr,
	periphWrite,
	periphWrData,
	periphRdData,
	xAddr,
	xDataOut,
	xDataOutEn,
	xDataIn,
	xChipSelN,
	xWriteN,
	xReadN,
	xClk
);
	input wire clk;
	input wire rst;
	input wire req;
	input wire fetch;
	input wire write;
	input wire [1:0] size;
	input wire [31:0] addr;
	input wire [31:0] wrData;
	input wire viaPrivBus;
	input wire xmemSync;
	input wire xmemWide;
	output reg done;
	output reg busError;
	output reg [31:0] rdData;
	output wire codeBusSel;
	output wire sysBusSel;
	output wire privBusSel;
	output reg [3:0] periphSel;
	output reg [31:0] periphAddr;
	output reg periphWrite;
	output reg [31:0] periphWrData;
	input wire [31:0] periphRdData;
	output reg [`SAD_XADDR_W-1:0] xAddr;
	output reg [15:0] xDataOut;
	output reg xDataOutEn;
	input wire [15:0] xDataIn;
	output reg xChipSelN;
	output reg xWriteN;
	output reg xReadN;
	output reg xClk;

	localparam ST_IDLE = 3'd0;
	localparam ST_SRAM = 3'd1;
	localparam ST_BBWR = 3'd2;
	localparam ST_XMEM = 3'd3;
	localparam ST_PERI = 3'd4;
	localparam ST_DONE = 3'd5;
	localparam [2:0] XCYC = `SAD_XCYCLES;

	////////////////////////////////////////////////////////////////
	function inr;
		input [31:0] a;
		input [31:0] lo;
		input [31:0] hi;
		begin
			inr = (a >= lo) && (a <= hi);
		end
	endfunction

	function [3:0] target;
		input [31:0] a;
		input priv;
		begin
			target = `SAD_T_NONE;
			if (inr(a, `SAD_PRIV_BASE, `SAD_PRIV_END)) begin
				target = priv ? `SAD_T_PRIV : `SAD_T_NONE;
			end else if (a <= `SAD_CODE_END) begin
				if (a <= `SAD_FLASH_END) target = `SAD_T_FLASH;
				else if (a >= `SAD_SRAM_LO_BASE) target = `SAD_T_SRAM;
			end else if (a < `SAD_PERI_BASE) begin
				if (inr(a, `SAD_SRAM_BASE, `SAD_SRAM_HI_END)) target = `SAD_T_SRAM;
				else if (inr(a, `SAD_ALIAS_BASE, `SAD_ALIAS_END)) target = `SAD_T_SRAM;
			end else if (a < `SAD_XRAM_BASE) begin
				if (inr(a, `SAD_CLK_BASE, `SAD_CLK_END)) target = `SAD_T_CLK;
				else if (inr(a, `SAD_PWR_BASE, `SAD_PWR_END)) target = `SAD_T_PWR;
				else if (inr(a, `SAD_XCTL_BASE, `SAD_XCTL_END)) target = `SAD_T_XCTL;
				else if (inr(a, `SAD_USB_BASE, `SAD_USB_END)) target = `SAD_T_USB;
				else if (inr(a, `SAD_NVB_BASE, `SAD_NVB_END)) target = `SAD_T_NVB;
				else if (inr(a, `SAD_ECC_BASE, `SAD_ECC_END)) target = `SAD_T_ECC;
				else if (inr(a, `SAD_RSV_BASE, `SAD_RSV_END)) target = `SAD_T_NONE;
			end else if (a < `SAD_XPERI_BASE) begin
				if (a <= `SAD_XDATA_END) target = `SAD_T_XMEM;
			end else if (a >= `SAD_SYSHI_BASE || a < `SAD_PRIV_BASE) begin
				target = `SAD_T_SYS;
			end
		end
	endfunction

	// only flash, SRAM and external memory hold code; anything else refuses a fetch
	function fetchable;
		input [3:0] t;
		begin
			fetchable = (t == `SAD_T_FLASH) || (t == `SAD_T_SRAM) || (t == `SAD_T_XMEM);
		end
	endfunction

	////////////////////////////////////////////////////////////////
	wire [3:0] tgt = target(addr, viaPrivBus);
	wire inAlias = inr(addr, `SAD_ALIAS_BASE, `SAD_ALIAS_END);
	// alias = base + 32*offset + 4*bit, so offset and bit fall out of the alias address
	wire [19:0] bbByte = addr[24:5];
	wire [4:0] bbBit = {bbByte[1:0], addr[4:2]};
	// bit-band base is 1 MB but only the first 32 KB is populated
	wire bbHit = (bbByte <= 20'h0_7FFF);
	wire [3:0] tgtEff = (inAlias && !bbHit) ? `SAD_T_NONE : tgt;
	assign codeBusSel = req && (addr <= `SAD_CODE_END);
	wire inPrivWin = inr(addr, `SAD_PRIV_BASE, `SAD_PRIV_END);
	assign sysBusSel = req && !viaPrivBus && (addr >= `SAD_SRAM_BASE) && !inPrivWin;
	assign privBusSel = req && (tgtEff == `SAD_T_PRIV);

	// byte lanes and beat split for unaligned accesses
	wire [1:0] ofs = addr[1:0];
	wire [2:0] nbytes = (size == 2'd0) ? 3'd1 : ((size == 2'd1) ? 3'd2 : 3'd4);
	wire [3:0] spanEnd = {2'b00, ofs} + {1'b0, nbytes};
	wire twoBeats = (spanEnd > 4'd4);
	wire [7:0] laneMask = ((8'h01 << nbytes) - 8'h01) << ofs;
	wire [63:0] wrShift = {32'h0000_0000, wrData} << {ofs, 3'b000};

	////////////////////////////////////////////////////////////////
	reg [2:0] state_q;
	reg beat_q;
	reg [2:0] cnt_q;
	reg [63:0] rdBuf_q;
	reg [4:0] bit_q;
	reg [1:0] xLane_q;
	reg xSync_q;
	reg xWide_q;
	reg [`SAD_SRAM_AW-1:0] ramAddr;
	reg ramWe;
	reg [3:0] ramBe;
	reg [31:0] ramWd;
	wire [31:0] ramRd;
	wire [`SAD_SRAM_AW-1:0] wordIdx = addr[`SAD_SRAM_AW+1:2];
	wire [`SAD_SRAM_AW-1:0] bbIdx = bbByte[`SAD_SRAM_AW+1:2];
	// the RAM answers one clock late, so a split read presents its second word a beat early
	wire readAhead = (state_q == ST_SRAM) && !write && !inAlias && twoBeats && !beat_q;

	// SRAM port: bank chosen by address bit 29 region; low half sits at top of code
	always @* begin
		ramAddr = inAlias ? bbIdx : ({~addr[29], wordIdx[`SAD_SRAM_AW-2:0]} + {{(`SAD_SRAM_AW-1){1'b0}}, beat_q | readAhead});
		ramWe = 1'b0;
		ramBe = 4'h0;
		ramWd = 32'h0000_0000;
		if (state_q == ST_SRAM && write && !inAlias) begin
			ramWe = 1'b1;
			ramBe = beat_q ? laneMask[7:4] : laneMask[3:0];
			ramWd = beat_q ? wrShift[63:32] : wrShift[31:0];
		end else if (state_q == ST_BBWR) begin
			// read-modify-write within one locked sequence keeps the bit atomic
			ramWe = 1'b1;
			ramBe = 4'hF;
			ramWd = ramRd & ~(32'h0000_0001 << bit_q);
			if (wrData[0]) ramWd = ramWd | (32'h0000_0001 << bit_q);
		end
	end

	sad_sram u_sram (
		.clk(clk),
		.addr(ramAddr),
		.wrEn(ramWe),
		.byteEn(ramBe),
		.wrData(ramWd),
		.rdData(ramRd)
	);

	////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		if (rst) begin
			state_q <= ST_IDLE;
			beat_q <= 1'b0;
			cnt_q <= 3'h0;
			rdBuf_q <= 64'h0000_0000_0000_0000;
			bit_q <= 5'h00;
			xLane_q <= 2'h0;
			xSync_q <= 1'b0;
			xWide_q <= 1'b0;
			done <= 1'b0;
			busError <= 1'b0;
			rdData <= 32'h0000_0000;
			periphSel <= `SAD_T_NONE;
			periphAddr <= 32'h0000_0000;
			periphWrite <= 1'b0;
			periphWrData <= 32'h0000_0000;
			xAddr <= {`SAD_XADDR_W{1'b0}};
			xDataOut <= 16'h0000;
			xDataOutEn <= 1'b0;
			xChipSelN <= 1'b1;
			xWriteN <= 1'b1;
			xReadN <= 1'b1;
			xClk <= 1'b0;
		end else begin
			done <= 1'b0;
			busError <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					beat_q <= 1'b0;
					bit_q <= bbBit;
					if (req) begin
						if (tgtEff == `SAD_T_NONE || (fetch && !fetchable(tgtEff))) begin
							busError <= 1'b1;
							done <= 1'b1;
							state_q <= ST_DONE;
						end else if (tgtEff == `SAD_T_SRAM) begin
							state_q <= ST_SRAM;
						end else if (tgtEff == `SAD_T_XMEM) begin
							// fetches allowed here, no protection check on this region
							cnt_q <= 3'h0;
							xLane_q <= 2'h0;
							// mode frozen per access so a mid-transfer change cannot mix device types
							xSync_q <= xmemSync;
							xWide_q <= xmemWide;
							xAddr <= addr[`SAD_XADDR_W-1:0];
							xChipSelN <= 1'b0;
							xReadN <= write;
							xWriteN <= ~write;
							xDataOut <= wrData[15:0];
							xDataOutEn <= write;
							state_q <= ST_XMEM;
						end else begin
							// other targets handed to peripheral and logic blocks
							periphSel <= tgtEff;
							periphAddr <= addr;
							periphWrite <= write;
							periphWrData <= wrData;
							state_q <= ST_PERI;
						end
					end
				end
				ST_SRAM: begin
					if (inAlias) begin
						if (write) begin
							state_q <= ST_BBWR;
						end else begin
							rdData <= {31'h0000_0000, ramRd[bit_q]};
							done <= 1'b1;
							state_q <= ST_DONE;
						end
					end else begin
						if (beat_q) rdBuf_q[63:32] <= ramRd;
						else rdBuf_q[31:0] <= ramRd;
						if (twoBeats && !beat_q) begin
							beat_q <= 1'b1;
						end else begin
							done <= 1'b1;
							if (!write) rdData <= twoBeats ? rdAligned_next(rdBuf_q[31:0], ramRd, ofs) :
								(ramRd >> {ofs, 3'b000});
							state_q <= ST_DONE;
						end
					end
				end
				ST_BBWR: begin
					done <= 1'b1;
					state_q <= ST_DONE;
				end
				ST_XMEM: begin
					// four bus clocks per beat; 8-bit mode steps one byte lane per beat
					cnt_q <= cnt_q + 3'h1;
					xClk <= xSync_q ? ~xClk : 1'b0;
					if (cnt_q == XCYC - 3'h1) begin
						cnt_q <= 3'h0;
						if (!write) begin
							if (xWide_q) rdData[15:0] <= xDataIn;
							else rdData <= rdData | ({24'h00_0000, xDataIn[7:0]} << {xLane_q, 3'b000});
						end
						if (xWide_q || xLane_q == nbytes[1:0] - 2'h1 || nbytes == 3'd1) begin
							xChipSelN <= 1'b1;
							xReadN <= 1'b1;
							xWriteN <= 1'b1;
							xDataOutEn <= 1'b0;
							xClk <= 1'b0;
							done <= 1'b1;
							state_q <= ST_DONE;
						end else begin
							xLane_q <= xLane_q + 2'h1;
							xAddr <= xAddr + {{(`SAD_XADDR_W-1){1'b0}}, 1'b1};
							xDataOut <= {8'h00, wrData[8*xLane_q+15 -: 8]};
						end
					end
				end
				ST_PERI: begin
					rdData <= periphRdData;
					periphSel <= `SAD_T_NONE;
					done <= 1'b1;
					state_q <= ST_DONE;
				end
				ST_DONE: begin
					rdBuf_q <= 64'h0000_0000_0000_0000;
					if (!req) begin
						if (!write) rdData <= rdData;
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
			if (state_q == ST_IDLE && req && tgtEff == `SAD_T_XMEM) rdData <= 32'h0000_0000;
		end
	end

	function [31:0] rdAligned_next;
		input [31:0] lo;
		input [31:0] hi;
		input [1:0] o;
		reg [63:0] w;
		begin
			w = {hi, lo} >> {o, 3'b000};
			rdAligned_next = w[31:0];
		end
	endfunction
endmodule

// ### tb/sad_decoder_asserts.sv
// port checker for the address decoder
// bound to sad_decoder from the testbench, sees its ports only
`timescale 1ns/10ps
`include "sad_defines.vh"
module sad_decoder_asserts (
	input wire clk,
	input wire rst,
	input wire req,
	input wire fetch,
	input wire write,
	input wire [31:0] addr,
	input wire viaPrivBus,
	input wire done,
	input wire busError,
	input wire codeBusSel,
	input wire sysBusSel,
	input wire [3:0] periphSel,
	input wire xDataOutEn,
	input wire xChipSelN
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire inPriv = addr >= `SAD_PRIV_BASE && addr <= `SAD_PRIV_END;
	wire inX = addr >= `SAD_XRAM_BASE && addr <= `SAD_XDATA_END;
	sequence sCsLow;
		!xChipSelN [*4];
	endsequence
	sequence sDone;
		##[1:20] done;
	endsequence
	//////////////////////////////////////////////////////////////
	a_err_done: assert property (busError |-> done) else $error("error without done");
	a_done_pulse: assert property ($rose(req) |-> sDone) else $error("access never finished");
	a_code_range: assert property (codeBusSel |-> addr <= `SAD_CODE_END) else $error("code bus out of range");
	a_sys_range: assert property (sysBusSel |-> (addr >= `SAD_SRAM_BASE && addr < `SAD_PRIV_BASE)
		|| addr >= `SAD_SYSHI_BASE) else $error("system bus out of range");
	a_priv_only: assert property (done && !busError && inPriv |-> viaPrivBus) else $error("private window leaked");
	a_xcs_hold: assert property ($fell(xChipSelN) |-> sCsLow) else $error("external access too short");
	a_xcs_window: assert property (!xChipSelN |-> inX) else $error("external select outside window");
	a_xdrive_write: assert property (xDataOutEn |-> write && !xChipSelN) else $error("data driven on read");
	a_xfetch_ok: assert property (done && fetch && inX |-> !busError) else $error("external fetch refused");
	a_clk_window: assert property (periphSel == `SAD_T_CLK |-> addr >= `SAD_CLK_BASE && addr <= `SAD_CLK_END)
		else $error("clock block misdecoded");
endmodule

// ### tb/sad_far_model.sv
// far side: external memory device and peripheral read data
// memory answers while selected; released bus shows inverse of last value
`timescale 1ns/10ps
`include "sad_defines.vh"
module sad_far_model (
	input wire clk,
	input wire [`SAD_XADDR_W-1:0] xAddr,
	input wire [15:0] xDataOut,
	input wire xChipSelN,
	input wire xWriteN,
	input wire xReadN,
	output logic [15:0] xDataIn,
	input wire [3:0] periphSel,
	output logic [31:0] periphRdData
);
	logic [15:0] mem [0:31];
	logic [15:0] lastQ = 16'h0000;
	wire rdOn = !xChipSelN && !xReadN;
	always @(posedge clk) begin
		if (!xChipSelN && !xWriteN) begin
			mem[xAddr[4:0]] <= xDataOut;
		end
		if (rdOn) begin
			lastQ <= mem[xAddr[4:0]];
		end
	end
	assign xDataIn = rdOn ? mem[xAddr[4:0]] : ~lastQ;
	// target code echoed while selected, so a wrong select shows in the data
	assign periphRdData = {16'h5A5A, 12'h000, periphSel};
endmodule

// ### tb/sad_decoder_tb.sv
// self-checking bench for sad_decoder with a far-side model
// external memory mostly asynchronous; one read repeated in synchronous mode
`timescale 1ns/10ps
`include "sad_defines.vh"
module sad_decoder_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic req = 1'b0, fetch = 1'b0, write = 1'b0, viaPrivBus = 1'b0, xmemWide = 1'b1, xmemSync = 1'b0;
	logic [1:0] size = 2'h2;
	logic [31:0] addr = 32'h0000_0000, wrData = 32'h0000_0000, rd;
	logic err;
	logic [2:0] sel;
	wire done, busError, codeBusSel, sysBusSel, privBusSel, periphWrite, xDataOutEn, xChipSelN, xWriteN, xReadN, xClk;
	wire [31:0] rdData, periphAddr, periphWrData, periphRdData;
	wire [3:0] periphSel;
	wire [`SAD_XADDR_W-1:0] xAddr;
	wire [15:0] xDataOut, xDataIn;
	int n_fail = 0, checked = 0, cyc = 0, lat, xRise = 0;
	always #10 clk = ~clk;
	always @(posedge xClk) begin
		xRise++;
	end
	sad_decoder sad_decoder_inst (.clk(clk), .rst(rst), .req(req), .fetch(fetch), .write(write), .size(size),
		.addr(addr), .wrData(wrData), .viaPrivBus(viaPrivBus), .xmemSync(xmemSync), .xmemWide(xmemWide),
		.done(done), .busError(busError), .rdData(rdData), .codeBusSel(codeBusSel), .sysBusSel(sysBusSel),
		.privBusSel(privBusSel), .periphSel(periphSel), .periphAddr(periphAddr), .periphWrite(periphWrite),
		.periphWrData(periphWrData), .periphRdData(periphRdData), .xAddr(xAddr), .xDataOut(xDataOut),
		.xDataOutEn(xDataOutEn), .xDataIn(xDataIn), .xChipSelN(xChipSelN), .xWriteN(xWriteN),
		.xReadN(xReadN), .xClk(xClk));
	sad_far_model sad_far_model_inst (.clk(clk), .xAddr(xAddr), .xDataOut(xDataOut), .xChipSelN(xChipSelN),
		.xWriteN(xWriteN), .xReadN(xReadN), .xDataIn(xDataIn), .periphSel(periphSel),
		.periphRdData(periphRdData));
	//////////////////////////////////////////////////////////////
	task automatic conclude;
		if (n_fail == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// lat counts edges from raising req until done is seen
	task automatic access(input logic [31:0] a, input logic w, input logic [1:0] s, input logic [31:0] d,
		input logic f);
		@(posedge clk);
		addr <= a;
		write <= w;
		size <= s;
		wrData <= d;
		fetch <= f;
		req <= 1'b1;
		lat = 0;
		do begin
			@(posedge clk);
			lat++;
			#1;
		end while (done !== 1'b1 && lat < 40);
		if (done !== 1'b1) begin
			n_fail++;
			conclude();
		end
		rd = rdData;
		err = busError;
		sel = {codeBusSel, sysBusSel, privBusSel};
		req <= 1'b0;
		@(posedge clk);
	endtask
	//////////////////////////////////////////////////////////////
	task automatic t_sram;
		access(32'h2000_0004, 1'b1, 2'h2, 32'hCAFE_F00D, 1'b0);
		chk(lat, 2);
		chk(sel, 3'b010);
		access(32'h1FFF_8000, 1'b1, 2'h2, 32'h0BAD_1234, 1'b0);
		chk(sel, 3'b100);
		access(32'h2000_0004, 1'b0, 2'h2, 32'h0000_0000, 1'b0);
		chk(rd, 32'hCAFE_F00D);
		access(32'h1FFF_8000, 1'b0, 2'h2, 32'h0000_0000, 1'b0);
		chk(rd, 32'h0BAD_1234);
		access(32'h2000_0008, 1'b1, 2'h2, 32'h0000_0000, 1'b0);
		access(32'h2000_0006, 1'b1, 2'h2, 32'h1122_3344, 1'b0);
		access(32'h2000_0004, 1'b0, 2'h2, 32'h0000_0000, 1'b0);
		chk(rd, 32'h3344_F00D);
		access(32'h2000_0006, 1'b0, 2'h2, 32'h0000_0000, 1'b0);
		chk(rd, 32'h1122_3344);
		chk(lat, 3);
	endtask
	task automatic t_bitband;
		access(32'h2000_0000, 1'b1, 2'h2, 32'h0000_0000, 1'b0);
		access(32'h2200_000C, 1'b1, 2'h2, 32'h0000_0001, 1'b0);
		access(32'h2200_000C, 1'b0, 2'h2, 32'h0000_0000, 1'b0);
		chk(rd, 32'h0000_0001);
		access(32'h2200_0008, 1'b0, 2'h2, 32'h0000_0000, 1'b0);
		chk(rd, 32'h0000_0000);
		access(32'h2000_0000, 1'b0, 2'h2, 32'h0000_0000, 1'b0);
		chk(rd, 32'h0000_0008);
	endtask
	task automatic t_errors;
		logic [31:0] bad [3] = '{32'h4000_A000, 32'hE000_0010, 32'h4000_0000};
		foreach (bad[i]) begin
			access(bad[i], 1'b0, 2'h2, 32'h0000_0000, 1'b0);
			chk(err, 1'b1);
			chk(lat, 1);
			chk(sel, {1'b0, bad[i][31:28] != 4'hE, 1'b0});
		end
		access(32'h4000_4000, 1'b0, 2'h2, 32'h0000_0000, 1'b1);
		chk(err, 1'b1);
		viaPrivBus <= 1'b1;
		access(32'hE000_0010, 1'b0, 2'h2, 32'h0000_0000, 1'b0);
		chk(err, 1'b0);
		chk(sel, 3'b001);
		viaPrivBus <= 1'b0;
		access(32'h0000_0000, 1'b0, 2'h2, 32'h0000_0000, 1'b1);
		chk(err, 1'b0);
		chk(sel, 3'b100);
	endtask
	task automatic t_periph;
		logic [31:0] pa [6] = '{32'h4000_4010, 32'h4000_4300, 32'h4000_5400, 32'h4000_60FF, 32'h4000_8000,
			32'h4800_7FFC};
		logic [3:0] pc [6] = '{`SAD_T_CLK, `SAD_T_PWR, `SAD_T_XCTL, `SAD_T_USB, `SAD_T_NVB, `SAD_T_ECC};
		foreach (pa[i]) begin
			access(pa[i], 1'b0, 2'h2, 32'h0000_0000, 1'b0);
			chk(rd, {16'h5A5A, 12'h000, pc[i]});
			chk(periphAddr, pa[i]);
		end
	endtask
	task automatic t_xmem;
		access(32'h6000_0010, 1'b1, 2'h1, 32'h0000_BEEF, 1'b0);
		chk(lat, 5);
		access(32'h6000_0010, 1'b0, 2'h1, 32'h0000_0000, 1'b0);
		chk(rd & 32'h0000_FFFF, 32'h0000_BEEF);
		xmemWide <= 1'b0;
		access(32'h6000_0021, 1'b1, 2'h0, 32'h0000_005C, 1'b0);
		access(32'h6000_0021, 1'b0, 2'h0, 32'h0000_0000, 1'b0);
		chk(rd & 32'h0000_00FF, 32'h0000_005C);
		access(32'h6000_0010, 1'b0, 2'h1, 32'h0000_0000, 1'b1);
		chk(err, 1'b0);
		chk(lat, 9);
		chk(xRise, 0);
		xmemSync <= 1'b1;
		xmemWide <= 1'b1;
		access(32'h6000_0010, 1'b0, 2'h1, 32'h0000_0000, 1'b0);
		chk(rd & 32'h0000_FFFF, 32'h0000_BEEF);
		chk(lat, 5);
		chk(xRise != 0, 1'b1);
		xmemSync <= 1'b0;
	endtask
	//////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			conclude();
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_sram();
		t_bitband();
		t_errors();
		t_periph();
		t_xmem();
		conclude();
	end
endmodule
bind sad_decoder sad_decoder_asserts sad_decoder_asserts_inst (.clk, .rst, .req, .fetch, .write, .addr,
	.viaPrivBus, .done, .busError, .codeBusSel, .sysBusSel, .periphSel, .xDataOutEn, .xChipSelN);
